// ### shared/cpw_consts.svh
`ifndef CPW_CONSTS_SVH
`define CPW_CONSTS_SVH
// Register offsets
`define CPW_ADR_PIN   8'h07
`define CPW_ADR_INTC  8'h0b
`define CPW_ADR_FLAGS 8'h0c
`define CPW_ADR_T1L   8'h0e
`define CPW_ADR_T1H   8'h0f
`define CPW_ADR_T1C   8'h10
`define CPW_ADR_T2    8'h11
`define CPW_ADR_T2C   8'h12
`define CPW_ADR_CCL   8'h15
`define CPW_ADR_CCH   8'h16
`define CPW_ADR_CCC   8'h17
`define CPW_ADR_DIR   8'h87
`define CPW_ADR_IEN   8'h8c
`define CPW_ADR_PR2   8'h92
// Field positions
`define CPW_F_UNIT    2
`define CPW_F_T2      1
`define CPW_F_T1      0
`define CPW_F_TRIS    2
`define CPW_F_PIN     2
`define CPW_F_T1ON    0
`define CPW_F_T2ON    2
// Reset values
`define CPW_RST_ZERO  8'h00
`define CPW_RST_PR2   8'hff
`define CPW_RST_DIR   8'h05
// Compare actions
`define CPW_M_SET     4'h8
`define CPW_M_CLR     4'h9
`define CPW_M_SWI     4'ha
`define CPW_M_SPEC    4'hb
// Clock phases per timer-2 step
`define CPW_QPHASES   4
// Last prescaler phase before a timer-2 step, for ratios 1, 4 and 16
`define CPW_PRE_LIM1  6'h03
`define CPW_PRE_LIM4  6'h0f
`define CPW_PRE_LIM16 6'h3f
`endif

// ### shared/cpw_pkg.sv
package cpw_pkg;
    // Operating class decoded from the mode bits
    typedef enum logic [3:0]
    {
        CPW_OFF     = 4'b0001,
        CPW_CAPTURE = 4'b0010,
        CPW_COMPARE = 4'b0100,
        CPW_PWM     = 4'b1000
    } cpw_mode_type;

    // One register bus request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cpw_bus_req_type;

    // Unit pin drive group
    typedef struct packed
    {
        logic out;
        logic oe;
    } cpw_pin_type;
endpackage

// ### src/cpw_timer2.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpw_consts.svh"
// Timer-2 time base: prescaler, period match and postscaler
module cpw_timer2
#(
    parameter int W = 8
)
(
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] period,
    input  wire logic [7:0]   ctrl,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count,
    output logic      [1:0]   frac,
    output logic              restart,
    output logic              post_evt
);
    // A count narrower than two bits cannot hold a useful period
    if (W < 2)
    begin : g_bad_width
        $error("cpw_timer2: W too small");
    end

    logic [5:0] pre;      // Clock phases and prescaler in one counter
    logic [3:0] post;     // Postscaler count of period matches
    wire  [5:0] pre_lim;  // Last value of pre before a step
    wire        tick;     // Timer-2 advances this cycle
    wire        run;

    // Ratio 1, 4 or 16 of four clock phases each
    assign pre_lim = ctrl[1] ? `CPW_PRE_LIM16 :
                     (ctrl[0] ? `CPW_PRE_LIM4 : `CPW_PRE_LIM1);
    // Low extension bits are the phase or prescaler bits below the count
    assign frac    = ctrl[1] ? pre[5:4] : (ctrl[0] ? pre[3:2] : pre[1:0]);
    assign run     = ctrl[`CPW_F_T2ON];
    assign tick    = run && (pre == pre_lim);
    assign restart = tick && (count == period);

    // Prescaler; a count write restarts it so the step is whole
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            pre <= 6'h00;
        else if (load || tick)
            pre <= 6'h00;
        else if (run)
            pre <= pre + 6'h01;
    end

    // Count; cleared on the step after it equals the period
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            count <= '0;
        else if (load)
            count <= load_val;
        else if (restart)
            count <= '0;
        else if (tick)
            count <= count + W'(1);
    end

    // Postscaler only paces its own flag, never the period
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            post     <= 4'h0;
            post_evt <= 1'b0;
        end
        else
        begin
            post_evt <= restart && (post == ctrl[6:3]);
            if (restart)
                post <= (post == ctrl[6:3]) ? 4'h0 : post + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### src/cpw_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpw_consts.svh"
// Compare and PWM unit with its timers and register file
module cpw_unit
#(
    parameter int DUTY_W = 10
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    input  wire cpw_pkg::cpw_bus_req_type req,
    output logic [7:0]                    reg_rdata,
    input  wire logic                     unit_pin_i,
    output cpw_pkg::cpw_pin_type          unit_pin,
    input  wire logic                     adc_enabled,
    output logic                          adc_start,
    output logic                          unit_irq
);
    // Only the 10-bit duty path is built; other widths would misalign
    // the shadow register with the 2-bit latch
    if (DUTY_W != 10)
    begin : g_bad_width
        $error("cpw_unit: duty width must be 10");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]  intctl;     // Stored only
    logic [2:0]  flags;      // Unit, timer-2, timer-1 overflow flags
    logic [2:0]  irq_en;     // Matching enables
    logic [7:0]  t1l;        // Timer-1 count pair
    logic [7:0]  t1h;
    logic [7:0]  timer1_control;
    logic [7:0]  timer2_control;
    logic [7:0]  pr2;        // Timer-2 period
    logic [7:0]  ccl;        // Compare low or pending duty high
    logic [7:0]  cch;        // Compare high or duty shadow
    logic [5:0]  ccctl;      // Duty low bits and mode bits
    logic [7:0]  dir;        // Pin direction, tristate bit 2
    logic [1:0]  duty_lo;    // Internal 2-bit duty latch
    logic        out_latch;  // Compare/PWM output latch
    logic        eq_q;       // Equality seen last cycle
    logic [7:0]  t2cnt;
    logic [1:0]  t2frac;
    logic        t2_restart;
    logic        t2_post;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    // Mode class from the mode bits; 00 with nonzero low bits stays off
    function automatic cpw_pkg::cpw_mode_type mode_of(input logic [3:0] m);
        case (m[3:2])
            2'b00:   mode_of = cpw_pkg::CPW_OFF;
            2'b01:   mode_of = cpw_pkg::CPW_CAPTURE;
            2'b10:   mode_of = cpw_pkg::CPW_COMPARE;
            default: mode_of = cpw_pkg::CPW_PWM;
        endcase
    endfunction

    // Write strobe for one offset
    function automatic logic hit(input cpw_pkg::cpw_bus_req_type r,
                                 input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // Mode class and its two active decodes
    wire cpw_pkg::cpw_mode_type mode = mode_of(ccctl[3:0]);
    wire is_cmp  = (mode == cpw_pkg::CPW_COMPARE);
    wire is_pwm  = (mode == cpw_pkg::CPW_PWM);
    // Write strobes, one for each register offset except the read-only pin offset
    wire w_intc  = hit(req, `CPW_ADR_INTC);
    wire w_flags = hit(req, `CPW_ADR_FLAGS);
    wire w_t1l   = hit(req, `CPW_ADR_T1L);
    wire w_t1h   = hit(req, `CPW_ADR_T1H);
    wire w_t1c   = hit(req, `CPW_ADR_T1C);
    wire w_t2    = hit(req, `CPW_ADR_T2);
    wire w_t2c   = hit(req, `CPW_ADR_T2C);
    wire w_ccl   = hit(req, `CPW_ADR_CCL);
    wire w_cch   = hit(req, `CPW_ADR_CCH);
    wire w_ccc   = hit(req, `CPW_ADR_CCC);
    wire w_dir   = hit(req, `CPW_ADR_DIR);
    wire w_ien   = hit(req, `CPW_ADR_IEN);
    wire w_pr2   = hit(req, `CPW_ADR_PR2);
    // Whole control register written with zero
    wire zero_wr = w_ccc && (req.wdata == `CPW_RST_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // Timer-1 and compare

    // Count pair and compare value as 16-bit words
    wire [15:0] t1      = {t1h, t1l};
    wire [15:0] cmp_val = {cch, ccl};
    // Timer 1 counts every clock while its run bit is set
    wire        t1_inc  = timer1_control[`CPW_F_T1ON];
    wire        eq      = (t1 == cmp_val);
    // Only the first cycle of equality counts, so a stalled timer acts once
    wire        match   = is_cmp && eq && !eq_q;
    // Special event trigger: reset of timer 1 and a conversion request
    wire        trig    = match && (ccctl[3:0] == `CPW_M_SPEC);
    // A wrap cut short by the trigger never counts as an overflow
    wire        t1_wrap = t1_inc && (t1 == 16'hffff) && !trig;
    // Next count value
    wire [15:0] t1_inc_v = t1 + 16'h0001;

    // Timer-1 count; the trigger outranks software and counting
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            t1l <= `CPW_RST_ZERO;
            t1h <= `CPW_RST_ZERO;
        end
        else if (trig)
        begin
            t1l <= `CPW_RST_ZERO;
            t1h <= `CPW_RST_ZERO;
        end
        else
        begin
            t1l <= w_t1l ? req.wdata : (t1_inc ? t1_inc_v[7:0] : t1l);
            t1h <= w_t1h ? req.wdata : (t1_inc ? t1_inc_v[15:8] : t1h);
        end
    end

    // Equality history and conversion start pulse
    // The pulse lags the trigger by one clock, landing on the same edge as the timer reset
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            eq_q      <= 1'b0;
            adc_start <= 1'b0;
        end
        else
        begin
            eq_q      <= eq;
            adc_start <= trig && adc_enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer-2 and PWM

    // Timer 2 steps every four clocks times the prescale ratio
    cpw_timer2 #(.W(8)) u_t2
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .period   (pr2),
        .ctrl     (timer2_control),
        .load     (w_t2),
        .load_val (req.wdata),
        .count    (t2cnt),
        .frac     (t2frac),
        .restart  (t2_restart),
        .post_evt (t2_post)
    );

    // Pending duty: high register over control bits 5:4
    wire [9:0] duty_pend = {ccl, ccctl[5:4]};
    wire       pwm_load  = is_pwm && t2_restart;
    // A duty beyond the period never meets the count, so the pin stays high
    wire       pwm_clr   = is_pwm && ({t2cnt, t2frac} == {cch, duty_lo});

    // Output latch shared by compare and PWM; branch order is priority:
    // zero write, period start, duty clear, then the compare actions
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            out_latch <= 1'b0;
        else if (zero_wr)
            out_latch <= 1'b0;
        else if (pwm_load)
            out_latch <= (duty_pend != 10'h000);
        else if (pwm_clr)
            out_latch <= 1'b0;
        else if (match && ccctl[3:0] == `CPW_M_SET)
            out_latch <= 1'b1;
        else if (match && ccctl[3:0] == `CPW_M_CLR)
            out_latch <= 1'b0;
    end

    // Shadow and 2-bit latch move only at a period match
    // Software may write the shadow only outside PWM mode
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cch     <= `CPW_RST_ZERO;
            duty_lo <= 2'b00;
        end
        else if (pwm_load)
        begin
            cch     <= ccl;
            duty_lo <= ccctl[5:4];
        end
        else if (w_cch && !is_pwm)
            cch <= req.wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    // Hardware sets win over a software write in the same cycle
    wire [2:0] flag_set = {match, t2_post, t1_wrap};
    wire [2:0] next_flags = (w_flags ? req.wdata[2:0] : flags) | flag_set;

    // Software registers; a write lands at the edge that takes the strobe
    // Flags are rewritten every clock so a set is never lost to a write
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            intctl <= `CPW_RST_ZERO;
            flags  <= 3'b000;
            irq_en <= 3'b000;
            timer1_control  <= `CPW_RST_ZERO;
            timer2_control  <= `CPW_RST_ZERO;
            pr2    <= `CPW_RST_PR2;
            ccl    <= `CPW_RST_ZERO;
            ccctl  <= 6'h00;
            dir    <= `CPW_RST_DIR;
        end
        else
        begin
            flags <= next_flags;
            if (w_intc) intctl <= req.wdata;
            if (w_ien)  irq_en <= req.wdata[2:0];
            if (w_t1c)  timer1_control  <= req.wdata;
            if (w_t2c)  timer2_control  <= req.wdata;
            if (w_pr2)  pr2    <= req.wdata;
            if (w_ccl)  ccl    <= req.wdata;
            if (w_ccc)  ccctl  <= req.wdata[5:0];
            if (w_dir)  dir    <= req.wdata;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    wire [7:0] next_rdata =
        !req.rd                      ? 8'h00 :
        (req.addr == `CPW_ADR_PIN)   ? {5'h00, unit_pin_i, 2'b00} :
        (req.addr == `CPW_ADR_INTC)  ? intctl :
        (req.addr == `CPW_ADR_FLAGS) ? {5'h00, flags} :
        (req.addr == `CPW_ADR_T1L)   ? t1l :
        (req.addr == `CPW_ADR_T1H)   ? t1h :
        (req.addr == `CPW_ADR_T1C)   ? timer1_control :
        (req.addr == `CPW_ADR_T2)    ? t2cnt :
        (req.addr == `CPW_ADR_T2C)   ? {1'b0, timer2_control[6:0]} :
        (req.addr == `CPW_ADR_CCL)   ? ccl :
        (req.addr == `CPW_ADR_CCH)   ? cch :
        (req.addr == `CPW_ADR_CCC)   ? {2'b00, ccctl} :
        (req.addr == `CPW_ADR_DIR)   ? dir :
        (req.addr == `CPW_ADR_IEN)   ? {5'h00, irq_en} :
        (req.addr == `CPW_ADR_PR2)   ? pr2 : 8'h00;

    // Registered read port; idle cycles return zero
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin and interrupt request

    // Driven only in compare or PWM with the tristate bit clear
    wire drive_en = (is_cmp || is_pwm) && !dir[`CPW_F_TRIS];
    // Both pin fields in one assignment, so the port has a single driver
    assign unit_pin = '{out: out_latch, oe: drive_en};
    // Level request: unit flag gated by its enable
    assign unit_irq = flags[`CPW_F_UNIT] && irq_en[`CPW_F_UNIT];

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Compare pin actions and the unit flag
    cmp_set_a: assert property (match && ccctl[3:0] == `CPW_M_SET && !zero_wr
        |=> out_latch) else $error("compare set did not drive pin high");
    cmp_clr_a: assert property (match && ccctl[3:0] == `CPW_M_CLR
        |=> !out_latch) else $error("compare clear did not drive pin low");
    match_flag_a: assert property (match |=> flags[`CPW_F_UNIT])
        else $error("match did not set unit flag");

    // Zero control write and the flag-only mode
    zero_ctl_a: assert property (zero_wr |=> !out_latch ##1 !out_latch)
        else $error("zero control write left latch high");
    swi_pin_a: assert property (match && ccctl[3:0] == `CPW_M_SWI && !w_ccc
        |=> $stable(out_latch)) else $error("software interrupt moved pin");

    // Special event trigger
    trig_reset_a: assert property (trig |=> t1 == 16'h0000)
        else $error("trigger did not reset timer-1");
    adc_go_a: assert property (trig |=> adc_start == $past(adc_enabled))
        else $error("conversion start wrong");
    trig_ovf_a: assert property (trig && !flags[`CPW_F_T1] && !w_flags
        |=> !flags[`CPW_F_T1]) else $error("trigger set overflow flag");
    // Conversion starts only while the converter is enabled
    adc_gate_a: assert property (adc_start |-> $past(adc_enabled))
        else $error("conversion started while converter disabled");

    // Period load, shadow and duty clearing; a zero write still wins
    shadow_load_a: assert property (pwm_load && !w_ccl
        |=> cch == $past(ccl)
            && out_latch == (($past(duty_pend) != 10'h000) && !$past(zero_wr)))
        else $error("period match load wrong");
    // The 2-bit latch takes control bits 5:4 together with the shadow
    duty_lo_a: assert property (pwm_load |=> duty_lo == $past(ccctl[5:4]))
        else $error("duty low bits not latched");
    shadow_hold_a: assert property (is_pwm && !t2_restart && !w_ccc
        |=> $stable(cch) && $stable(duty_lo)) else $error("shadow changed mid period");
    pwm_clr_a: assert property (pwm_clr && !pwm_load && !zero_wr
        |=> !out_latch) else $error("duty match did not clear pin");
    // A zero duty never raises the pin at the period start
    duty_zero_a: assert property (pwm_load && duty_pend == 10'h000
        |=> !out_latch) else $error("zero duty raised pin");
    // Timer 2 restarts from zero after the period match
    t2_clear_a: assert property (t2_restart && !w_t2 |=> t2cnt == 8'h00)
        else $error("timer-2 not cleared at period match");
    // A duty beyond the period cannot meet a count within the period
    big_duty_a: assert property (is_pwm && cch > pr2 && t2cnt <= pr2 |-> !pwm_clr)
        else $error("duty beyond period cleared pin");
    // The postscaler event only follows a period end and never paces it
    post_only_a: assert property (t2_post |-> $past(t2_restart))
        else $error("postscaler event without period end");

    // One action per equality; a driven pin needs an active mode
    one_match_a: assert property (match |=> !match)
        else $error("match repeated");
    pin_oe_a: assert property (unit_pin.oe |-> is_cmp || is_pwm)
        else $error("pin driven outside compare or pwm");

    cv_spec: cover property (trig ##1 adc_start);
    cv_period: cover property (pwm_load ##[1:300] pwm_clr);
    cv_cmp_set: cover property (match && ccctl[3:0] == `CPW_M_SET);
    cv_swi: cover property (match && ccctl[3:0] == `CPW_M_SWI);
    cv_big_duty: cover property (t2_restart && is_pwm && cch > pr2);
endmodule
`default_nettype wire

// ### dv/cpw_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far-side circuit on the unit pin; it has no pull resistor of its own
module cpw_pin_model
(
    input  wire logic                 clk_sys,
    input  wire cpw_pkg::cpw_pin_type unit_pin,
    output logic                      pin_level
);
    logic last_q = 1'b0; // Last level the unit drove

    ////////////////////////////////////////////////////////////////////////////
    // A released wire settles opposite to its last driven level, so a
    // stale value is never read back as a live one
    always @(posedge clk_sys)
    begin
        if (unit_pin.oe)
            last_q <= unit_pin.out;
    end

    // Unit drives only with its tristate bit cleared, else the wire floats
    assign pin_level = unit_pin.oe ? unit_pin.out : ~last_q;
endmodule
`default_nettype wire

// ### dv/tb_compare_pwm_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpw_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the compare and PWM unit
module tb_compare_pwm_unit;
    typedef struct packed {logic [7:0] addr; logic [7:0] val;} cpw_rst_row_type;
    typedef struct packed {logic [3:0] mode; logic adc; logic out;} cpw_cmp_row_type;
    typedef struct packed
    {
        logic [7:0] t2c;
        logic [7:0] ccl;
        logic [1:0] lo;
        logic [7:0] high;
    } cpw_pwm_row_type;

    localparam int PER = 16; // Clocks per PWM period: (3 + 1) steps of 4 phases

    logic                     clk_sys;     // System clock
    logic                     arst_n;      // Reset, active low
    cpw_pkg::cpw_bus_req_type req;         // Register bus request
    logic [7:0]               reg_rdata;   // Register read data
    logic                     pin_level;   // Resolved wire level
    cpw_pkg::cpw_pin_type     unit_pin;    // Unit pin drive
    logic                     adc_enabled; // Converter enable
    logic                     adc_start;   // Conversion start pulse
    logic                     unit_irq;    // Unit interrupt level
    int                       fails;       // Mismatches seen
    int                       checks_done; // Comparisons made
    int                       n;           // Wait and count helper
    logic [7:0]               rd;          // Last read value
    logic                     spec;        // Row uses the special trigger

    // Reset values plus one unmapped offset that must read zero
    cpw_rst_row_type rst_rows [6] = '{'{8'h92, 8'hff}, '{8'h87, 8'h05}, '{8'h17, 8'h00},
                                      '{8'h11, 8'h00}, '{8'h0c, 8'h00}, '{8'h40, 8'h00}};
    // Ordered so that the untouched modes follow a known latch level
    cpw_cmp_row_type cmp_rows [5] = '{'{4'h8, 1'b0, 1'b1}, '{4'ha, 1'b0, 1'b1},
                                      '{4'h9, 1'b0, 1'b0}, '{4'hb, 1'b1, 1'b0},
                                      '{4'hb, 1'b0, 1'b0}};
    // Duty in quarters; high time is duty plus the clearing edge, none for zero duty, the whole period beyond it
    cpw_pwm_row_type pwm_rows [5] = '{'{8'h04, 8'h02, 2'h0, 8'h09}, '{8'h04, 8'h01, 2'h3, 8'h08},
                                      '{8'h04, 8'h00, 2'h0, 8'h00}, '{8'h04, 8'h10, 2'h0, 8'h10},
                                      '{8'h7c, 8'h02, 2'h0, 8'h09}};

    ////////////////////////////////////////////////////////////////////////////
    cpw_unit u_dut
    (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .req         (req),
        .reg_rdata   (reg_rdata),
        .unit_pin_i  (pin_level),
        .unit_pin    (unit_pin),
        .adc_enabled (adc_enabled),
        .adc_start   (adc_start),
        .unit_irq    (unit_irq)
    );

    cpw_pin_model u_pin
    (
        .clk_sys   (clk_sys),
        .unit_pin  (unit_pin),
        .pin_level (pin_level)
    );

    // Clock at 200 MHz
    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    // Compare tasks; four-state equality so an unknown never matches
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One-cycle write strobe; idles one edge after so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req <= '0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // Bounded wait for the unit interrupt, sampled mid-cycle
    task automatic wait_irq;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (unit_irq !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            fails++;
            $display("[ERR] %0t no match seen", $time);
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        req = '0;
        adc_enabled = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (rst_rows[i])
        begin
            rdr(rst_rows[i].addr, rd);
            chk8(rd, rst_rows[i].val);
        end
        chk8({4'h0, unit_pin, adc_start, unit_irq}, 8'h00);
        $display("reset test done");

        // Compare actions; timer 1 runs in plain timer mode only
        wr(`CPW_ADR_DIR, 8'h01);
        wr(`CPW_ADR_IEN, 8'h04);
        wr(`CPW_ADR_CCL, 8'h20);
        wr(`CPW_ADR_CCH, 8'h00);
        foreach (cmp_rows[i])
        begin
            spec = (cmp_rows[i].mode == `CPW_M_SPEC);
            wr(`CPW_ADR_T1C, 8'h00);
            wr(`CPW_ADR_T1L, 8'h00);
            wr(`CPW_ADR_T1H, 8'h00);
            wr(`CPW_ADR_FLAGS, 8'h00);
            wr(`CPW_ADR_CCC, {4'h0, cmp_rows[i].mode});
            adc_enabled <= cmp_rows[i].adc;
            wr(`CPW_ADR_T1C, 8'h01);
            wait_irq();
            chk1(unit_pin.out, cmp_rows[i].out);
            chk1(unit_pin.oe, 1'b1);
            chk1(adc_start, cmp_rows[i].adc & spec);
            @(negedge clk_sys);
            chk1(adc_start, 1'b0);
            rdr(`CPW_ADR_T1L, rd);
            chk1(rd < 8'h20, spec);
            rdr(`CPW_ADR_FLAGS, rd);
            chk1(rd[`CPW_F_UNIT], 1'b1);
            chk1(rd[`CPW_F_T1], 1'b0);
            rdr(`CPW_ADR_PIN, rd);
            chk1(rd[`CPW_F_PIN], cmp_rows[i].out);
        end
        $display("compare test done");

        // Equality held with the timer stopped acts only once
        wr(`CPW_ADR_T1C, 8'h00);
        wr(`CPW_ADR_T1H, 8'h00);
        wr(`CPW_ADR_CCC, 8'h00);
        wr(`CPW_ADR_CCC, {4'h0, `CPW_M_SET});
        wr(`CPW_ADR_T1L, 8'h20);
        wr(`CPW_ADR_FLAGS, 8'h00);
        repeat (8) @(negedge clk_sys);
        rdr(`CPW_ADR_FLAGS, rd);
        chk1(rd[`CPW_F_UNIT], 1'b0);
        chk1(unit_pin.out, 1'b1);
        wr(`CPW_ADR_CCC, 8'h00);
        @(negedge clk_sys);
        chk1(unit_pin.out, 1'b0);
        $display("single match test done");

        // PWM rows, set up in the recommended order
        foreach (pwm_rows[i])
        begin
            wr(`CPW_ADR_PR2, 8'h03);
            wr(`CPW_ADR_CCL, pwm_rows[i].ccl);
            wr(`CPW_ADR_CCC, {2'b00, pwm_rows[i].lo, 4'h0});
            wr(`CPW_ADR_DIR, 8'h01);
            wr(`CPW_ADR_T2C, pwm_rows[i].t2c);
            wr(`CPW_ADR_CCC, {2'b00, pwm_rows[i].lo, 4'hc});
            wr(`CPW_ADR_CCH, 8'h5a);
            repeat (3 * PER) @(negedge clk_sys);
            n = 0;
            repeat (PER)
            begin
                @(negedge clk_sys);
                n += (unit_pin.out === 1'b1);
            end
            chk8(n[7:0], pwm_rows[i].high);
            chk1(unit_pin.oe, 1'b1);
            wr(`CPW_ADR_CCH, 8'h5a);
            rdr(`CPW_ADR_CCH, rd);
            chk8(rd, pwm_rows[i].ccl);
        end
        wr(`CPW_ADR_CCC, 8'h00);
        @(negedge clk_sys);
        chk1(unit_pin.out, 1'b0);
        $display("pwm test done");
        end_sim();
    end
endmodule
`default_nettype wire
